/* File: fwp_ctrl.v */
// programmer-side sequencer driving the flash writer-mode pins
`timescale 1ns/1ps
`include "fwp_consts.vh"
module fwp_ctrl (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // user request
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [16:0] req_addr,
  input wire [7:0] req_data,
  output reg req_ready,
  // user answer
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  // device pins
  output reg vpp_high,
  output reg ce_b,
  output reg oe_b,
  output reg we_b,
  output reg [16:0] addr,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire [7:0] data_in
);
  localparam ST_IDLE = 4'd0;
  localparam ST_VPP_UP = 4'd1;
  localparam ST_WR_LOW = 4'd2;
  localparam ST_WR_HIGH = 4'd3;
  localparam ST_RD_WAIT = 4'd4;
  localparam ST_RD_TAKE = 4'd5;
  localparam ST_DONE = 4'd6;
  localparam ST_VPP_DOWN = 4'd7;

  reg [3:0] st_q;
  reg [`FWP_CNT_W-1:0] cnt_q;
  reg [2:0] op_q;
  reg [16:0] addr_q;
  reg [7:0] data_q;
  reg second_q;
  wire [7:0] data_sync;

  // read-back bus passes four flops before use
  fwp_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  // first-cycle command byte of each operation
  function [7:0] first_byte;
    input [2:0] op;
    begin
      case (op)
        `FWP_OP_READ: first_byte = `FWP_CMD_READ;
        `FWP_OP_ERASE: first_byte = `FWP_CMD_ERASE;
        `FWP_OP_ERASE_VFY: first_byte = `FWP_CMD_ERASE_VFY;
        `FWP_OP_AUTO_ERASE: first_byte = `FWP_CMD_AUTO_ERASE;
        `FWP_OP_PROGRAM: first_byte = `FWP_CMD_PROGRAM;
        `FWP_OP_PROG_VFY: first_byte = `FWP_CMD_PROG_VFY;
        default: first_byte = `FWP_CMD_RESET;
      endcase
    end
  endfunction

  // second cycle is a write for erase, auto-erase, program and reset
  function second_is_write;
    input [2:0] op;
    begin
      case (op)
        `FWP_OP_ERASE, `FWP_OP_AUTO_ERASE, `FWP_OP_PROGRAM, `FWP_OP_RESET:
          second_is_write = 1'b1;
        default: second_is_write = 1'b0;
      endcase
    end
  endfunction

  // main sequencer; the device type is fixed by the user, never probed
  always @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      cnt_q <= {`FWP_CNT_W{1'b0}};
      op_q <= 3'h0;
      addr_q <= 17'h00000;
      data_q <= 8'h00;
      second_q <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      vpp_high <= 1'b0; // supply level, never ground
      ce_b <= 1'b1;
      oe_b <= 1'b1;
      we_b <= 1'b1;
      addr <= 17'h00000;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          ce_b <= 1'b1; // standby, bus floats
          oe_b <= 1'b1;
          we_b <= 1'b1;
          data_oe <= 1'b0;
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            op_q <= req_op;
            addr_q <= req_addr;
            data_q <= req_data;
            second_q <= 1'b0;
            cnt_q <= {`FWP_CNT_W{1'b0}};
            if (req_op == `FWP_OP_STANDBY) begin
              st_q <= ST_IDLE;
            end else begin
              // strobes stay high while vpp rises
              vpp_high <= 1'b1;
              st_q <= ST_VPP_UP;
            end
          end
        end
        ST_VPP_UP: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FWP_VPP_SETUP_CYC - 1) begin
            cnt_q <= {`FWP_CNT_W{1'b0}};
            // first cycle: command byte, check location rides along
            ce_b <= 1'b0;
            oe_b <= 1'b1;
            we_b <= 1'b0;
            addr <= addr_q;
            data_out <= first_byte(op_q);
            data_oe <= 1'b1;
            st_q <= ST_WR_LOW;
          end
        end
        ST_WR_LOW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FWP_WE_PULSE_CYC - 1) begin
            cnt_q <= {`FWP_CNT_W{1'b0}};
            we_b <= 1'b1; // device latches on this rising edge
            st_q <= ST_WR_HIGH;
          end
        end
        ST_WR_HIGH: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FWP_WE_HIGH_CYC - 1) begin
            cnt_q <= {`FWP_CNT_W{1'b0}};
            if (second_q) begin
              data_oe <= 1'b0;
              st_q <= ST_DONE;
            end else if (second_is_write(op_q)) begin
              // program sends its byte; others repeat the command
              second_q <= 1'b1;
              we_b <= 1'b0;
              if (op_q == `FWP_OP_PROGRAM) begin
                data_out <= data_q;
              end
              st_q <= ST_WR_LOW;
            end else begin
              // read phase: release bus and enable device output on the same edge
              data_oe <= 1'b0;
              oe_b <= 1'b0;
              st_q <= ST_RD_WAIT;
            end
          end
        end
        ST_RD_WAIT: begin
          // verify results need a long output setup, plain reads less
          cnt_q <= cnt_q + 1'b1;
          if ((op_q == `FWP_OP_READ && cnt_q == `FWP_READ_ACC_CYC + 2) ||
              cnt_q == `FWP_VERIFY_OE_CYC + 2) begin
            cnt_q <= {`FWP_CNT_W{1'b0}};
            st_q <= ST_RD_TAKE;
          end
        end
        ST_RD_TAKE: begin
          // stored byte, or 0xFF when erased
          rsp_data <= data_sync;
          oe_b <= 1'b1;
          st_q <= ST_DONE;
        end
        ST_DONE: begin
          ce_b <= 1'b1;
          oe_b <= 1'b1;
          we_b <= 1'b1;
          rsp_valid <= 1'b1;
          st_q <= ST_VPP_DOWN;
        end
        ST_VPP_DOWN: begin
          // drop vpp back to supply level only with all strobes high
          vpp_high <= 1'b0;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `FWP_VPP_SETUP_CYC - 1) begin
            cnt_q <= {`FWP_CNT_W{1'b0}};
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: fwp_consts.vh */
// constants for the flash writer-mode port programmer
// Functional notes
// - Vpp at supply, CE low, OE low, WE high: device drives addressed byte.
// - Commands only at programming Vpp; write cycle CE low, OE high, WE low.
// - Programmer raises Vpp to programming level for every operation except standby, reads included; supply level, never ground, only between operations.
// - Memory read: write 0x00 anywhere, then read cycles return stored bytes.
// - Erase: write 0x20 twice at any address; second write starts erase.
// - Erase-verify: write 0xA0 at check location, then read result byte.
// - Auto-erase: write 0x30 twice at any address to start automatic erase.
// - Program: write 0x40, then program byte at program location.
// - Program-verify: write 0xC0, then read the program-check result byte.
// - Reset: write 0xFF twice in succession to idle the command logic.
`ifndef FWP_CONSTS_VH
`define FWP_CONSTS_VH
`define FWP_CMD_READ 8'h00
`define FWP_CMD_ERASE 8'h20
`define FWP_CMD_ERASE_VFY 8'hA0
`define FWP_CMD_AUTO_ERASE 8'h30
`define FWP_CMD_PROGRAM 8'h40
`define FWP_CMD_PROG_VFY 8'hC0
`define FWP_CMD_RESET 8'hFF
`define FWP_ERASED_BYTE 8'hFF
`define FWP_OP_READ 3'h0
`define FWP_OP_ERASE 3'h1
`define FWP_OP_ERASE_VFY 3'h2
`define FWP_OP_AUTO_ERASE 3'h3
`define FWP_OP_PROGRAM 3'h4
`define FWP_OP_PROG_VFY 3'h5
`define FWP_OP_RESET 3'h6
`define FWP_OP_STANDBY 3'h7
// pin timing in ns, counts derived at 25 ns per cycle
`define FWP_CLK_NS 25
`define FWP_VPP_SETUP_NS 100
`define FWP_VPP_SETUP_CYC ((`FWP_VPP_SETUP_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_WE_PULSE_NS 70
`define FWP_WE_PULSE_CYC ((`FWP_WE_PULSE_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_WE_HIGH_NS 40
`define FWP_WE_HIGH_CYC ((`FWP_WE_HIGH_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_VERIFY_OE_NS 6000
`define FWP_VERIFY_OE_CYC ((`FWP_VERIFY_OE_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_READ_ACC_NS 500
`define FWP_READ_ACC_CYC ((`FWP_READ_ACC_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_CNT_W 8
`endif

/* File: fwp_sync.v */
// three-stage synchroniser for the data pins read back from the device
`timescale 1ns/1ps
module fwp_sync (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // asynchronous byte in, settled byte out
  input wire [7:0] async_in,
  output reg [7:0] sync_out
);
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  reg [7:0] s3_q;
  // a bit only moves once the second and third stage agree, so a
  // metastable first stage never reaches the output
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always @(posedge core_clk) begin
        if (!rst_b) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            sync_out[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

/* File: fwp_props.sv */
// assertions on the writer-mode programmer pins
`timescale 1ns/1ps
module fwp_props (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // user side and device pins
  input wire req_ready,
  input wire vpp_high,
  input wire ce_b,
  input wire oe_b,
  input wire we_b,
  input wire data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  rst_idle_a: assert property (disable iff (1'b0) !rst_b |=> ce_b && we_b && !vpp_high)
    else $error("pins not parked in reset");
  write_strobe_a: assert property (!we_b |-> !ce_b && oe_b && vpp_high && data_oe)
    else $error("bad command write cycle");
  no_fight_a: assert property (!oe_b |-> !data_oe && we_b)
    else $error("bus driven while device outputs");
  vpp_setup_a: assert property ($rose(vpp_high) |-> (ce_b && we_b)[*4])
    else $error("strobe before programming level settled");
  vpp_quiet_a: assert property ($changed(vpp_high) |-> ce_b && oe_b && we_b)
    else $error("level moved with a strobe low");
  we_width_a: assert property ($fell(we_b) |-> !we_b[*3])
    else $error("write pulse too short");
  we_gap_a: assert property ($rose(we_b) |-> we_b[*2])
    else $error("write high time too short");
  idle_pins_a: assert property (req_ready |-> ce_b && we_b && oe_b && !data_oe)
    else $error("pins active while idle");
endmodule
bind fwp_ctrl fwp_props u_props (.core_clk(core_clk), .rst_b(rst_b), .req_ready(req_ready),
  .vpp_high(vpp_high), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .data_oe(data_oe));

/* File: fwp_flash_model.sv */
// behavioural flash device answering the writer-mode pins
`timescale 1ns/1ps
module fwp_flash_model (
  // strobes and level
  input wire vpp_high,
  input wire ce_b,
  input wire oe_b,
  input wire we_b,
  // buses
  input wire [16:0] addr,
  input wire [7:0] data_out,
  input wire data_oe,
  output reg [7:0] data_in
);
  reg [7:0] mem_q [0:131071];
  reg [7:0] cmd_q = 8'h00;
  reg arm_q = 1'b0;
  reg [16:0] loc_q = 17'h0;
  reg [7:0] rd;
  integer i;
  // whole array starts erased
  initial for (i = 0; i < 131072; i = i + 1) mem_q[i] = 8'hFF;
  // capture on the strobe's rising edge, only at programming level
  always @(posedge we_b) if (!ce_b && oe_b && vpp_high && data_oe) begin
    if (arm_q) begin
      if (cmd_q == 8'h40) mem_q[addr] = data_out;
      if (cmd_q == 8'h40) loc_q = addr;
      if ((cmd_q == 8'h20 || cmd_q == 8'h30) && data_out == cmd_q)
        for (i = 0; i < 131072; i = i + 1) mem_q[i] = 8'hFF;
      arm_q = 1'b0;
    end else begin
      // no identifier command exists, unknown codes change nothing
      case (data_out)
        8'h20, 8'h30, 8'h40, 8'hFF: begin
          cmd_q = data_out;
          arm_q = 1'b1;
        end
        8'h00, 8'hC0: cmd_q = data_out;
        8'hA0: begin
          cmd_q = data_out;
          loc_q = addr;
        end
        default: ;
      endcase
    end
  end
  // released bus shows the inverse so a stale byte cannot pass
  always @* begin
    rd = (cmd_q == 8'h00) ? mem_q[addr] : mem_q[loc_q];
    data_in = (!ce_b && !oe_b && we_b) ? rd : ~rd;
  end
endmodule

/* File: fwp_ctrl_bench.sv */
// self-checking bench for the writer-mode programmer
`timescale 1ns/1ps
module fwp_ctrl_bench;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg req_valid = 1'b0;
  reg [2:0] req_op = 3'h7;
  reg [16:0] req_addr = 17'h0;
  reg [7:0] req_data = 8'h00;
  reg seen = 1'b0;
  wire req_ready, rsp_valid, vpp_high, ce_b, oe_b, we_b, data_oe;
  wire [7:0] rsp_data, data_out, data_in;
  wire [16:0] addr;
  integer err_count = 0;
  integer cmp_count = 0;
  fwp_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .vpp_high(vpp_high), .ce_b(ce_b),
    .oe_b(oe_b), .we_b(we_b), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in));
  fwp_flash_model u_dev (.vpp_high(vpp_high), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
    .addr(addr), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  // 40 MHz clock
  initial forever #12.5 core_clk = ~core_clk;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // hold the request until taken, then wait a bounded time for the answer
  task run(input [2:0] op, input [16:0] a, input [7:0] d);
    integer n;
    begin
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_data = d;
      while (req_ready !== 1'b1) begin @(posedge core_clk); #2; end
      @(posedge core_clk); #2;
      req_valid = 1'b0;
      seen = 1'b0;
      for (n = 0; n < 400 && !seen; n = n + 1) begin
        seen = (rsp_valid === 1'b1);
        if (!seen) begin @(posedge core_clk); #2; end
      end
      // a missing answer counts, so stale result bytes cannot pass a later check
      if (op != 3'h7) chk({7'h0, seen}, 8'h01);
    end
  endtask
  task t_blank;
    begin
      run(3'h0, 17'h1FFFF, 8'h00);
      chk(rsp_data, 8'hFF);
    end
  endtask
  task t_prog;
    begin
      run(3'h4, 17'h0ABCD, 8'h5A);
      run(3'h0, 17'h0ABCD, 8'h00);
      chk(rsp_data, 8'h5A);
      run(3'h5, 17'h0ABCD, 8'h00);
      chk(rsp_data, 8'h5A);
      run(3'h2, 17'h0ABCD, 8'h00);
      chk(rsp_data, 8'h5A);
    end
  endtask
  task t_erase;
    begin
      run(3'h1, 17'h0, 8'h00);
      run(3'h2, 17'h0ABCD, 8'h00);
      chk(rsp_data, 8'hFF);
      run(3'h4, 17'h00010, 8'hC3);
      run(3'h3, 17'h0, 8'h00);
      run(3'h0, 17'h00010, 8'h00);
      chk(rsp_data, 8'hFF);
    end
  endtask
  task t_misc;
    begin
      run(3'h6, 17'h0, 8'h00);
      chk({7'h0, seen}, 8'h01);
      run(3'h7, 17'h0, 8'h00);
      chk({7'h0, seen}, 8'h00);
    end
  endtask
  task end_of_test;
    begin
      $display("err_count %0d cmp_count %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // watchdog far beyond the thousand-odd cycles the tests need
  initial begin
    #(25 * 20000);
    err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #2;
    rst_b = 1'b1;
    @(posedge core_clk); #2;
    t_blank;
    t_prog;
    t_erase;
    t_misc;
    end_of_test;
  end
endmodule
